/* File: logic/adc_result_params.svh */
// Register offsets, field positions and timing counts of the result block
`ifndef ADC_RESULT_PARAMS_SVH
`define ADC_RESULT_PARAMS_SVH

`define OFS_CONTROL_0     8'h00
`define OFS_CONTROL_1     8'h04
`define OFS_CONTROL_2     8'h08
`define OFS_RESULT_HIGH   8'h0C
`define OFS_RESULT_LOW    8'h10
`define OFS_IRQ_STATUS    8'h14
`define OFS_IRQ_MASK      8'h18

`define POS_CONVERTER_ON  0
`define POS_GO            1
`define POS_CHANNEL_LO    2
`define POS_CHANNEL_HI    6
`define POS_JUSTIFY       7
`define POS_CLKSEL_LO     4
`define POS_CLKSEL_HI     6
`define POS_REFSEL_LO     0
`define POS_REFSEL_HI     1
`define POS_AUTO_TRIGGER_SELECT_LO    4
`define POS_AUTO_TRIGGER_SELECT_HI    7
`define POS_DONE          0

`define CONTROL_RESET     8'h00
`define CONV_CYCLES       8'h0C
`define TRIGGER_COUNT     10
`define ACQ_CYCLES        8

`endif

/* File: logic/adc_result_pkg.sv */
// Types shared by the result formatting block
package adc_result_pkg;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } result_pair_type;

    typedef enum logic [1:0] {
        IDLE    = 2'b01,
        CONVERT = 2'b10
    } conv_state_type;

endpackage : adc_result_pkg

/* File: logic/result_packer.sv */
// Packs a 10-bit conversion result into the two result bytes
`timescale 1ns/1ps

module result_packer
    import adc_result_pkg::*;
(
    input  wire logic            rightJustify,
    input  wire logic [9:0]      conversionResult,
    output result_pair_type      resultPair
);

    always_comb
    begin
        if (rightJustify)
        begin
            resultPair.high = {6'h00, conversionResult[9:8]}; // RULE3 RULE8
            resultPair.low  = conversionResult[7:0];          // RULE4
        end
        else
        begin
            resultPair.high = conversionResult[9:2];          // RULE1
            resultPair.low  = {conversionResult[1:0], 6'h00}; // RULE2 RULE8
        end
    end

endmodule : result_packer

/* File: logic/adc_result_formatting.sv */
// Converter control, result registers and APB slave of the 10-bit converter
//
// What this block does
// RULE1: Left justified, result bits 9..2 fill the whole high result byte.
// RULE2: Left justified, result bits 1..0 go to low byte bits 7..6.
// RULE3: Right justified, result bits 9..8 go to high byte bits 1..0.
// RULE4: Right justified, result bits 7..0 fill the whole low result byte.
// RULE5: Software waits an acquisition interval after a channel change.
// RULE6: Both result bytes are read/write and no reset touches them.
// RULE7: Software sets the go flag and hardware clears it on completion.
// RULE8: The six unused result bits are loaded as zero.
// RULE9: Bit 7 of control register 1 selects right (1) or left (0).
// RULE10: Both result bytes load in the cycle the go flag clears.
`timescale 1ns/1ps
`include "adc_result_params.svh"

module adc_result_formatting
    import adc_result_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  analogResult,
    input  wire logic [`TRIGGER_COUNT:1] triggerIn,
    output logic             irq,
    output logic             converterOn,
    output logic      [4:0]  channelSelect
);

    localparam int ConvDepth = 12;

    logic [7:0]  resultHigh;
    logic [7:0]  resultLow;
    logic        justifySelect;
    logic [2:0]  clockSelect;
    logic [1:0]  refSelect;
    logic [3:0]  triggerSelect;
    logic        doneStatus;
    logic        doneMask;
    logic        goFlag;
    logic [7:0]  convCount;
    conv_state_type convState;
    logic [9:0]  analogMeta;
    logic [9:0]  analogSync;
    logic [`TRIGGER_COUNT:1] trigMeta;
    logic [`TRIGGER_COUNT:1] trigSync;
    logic [`TRIGGER_COUNT:1] trigPrev;
    logic        setupPhase;
    logic        accessDone;
    logic        wrEn;
    logic        rdEn;
    logic        trigHit;
    logic        startReq;
    logic        abortReq;
    logic        loadStrobe;
    logic        loadedOnce;
    result_pair_type packedResult;

    function automatic logic addr_ok(input logic [7:0] addr);
        addr_ok = (addr == `OFS_CONTROL_0) || (addr == `OFS_CONTROL_1)
               || (addr == `OFS_CONTROL_2) || (addr == `OFS_RESULT_HIGH)
               || (addr == `OFS_RESULT_LOW) || (addr == `OFS_IRQ_STATUS)
               || (addr == `OFS_IRQ_MASK);
    endfunction : addr_ok

    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        unique case (addr)
            `OFS_CONTROL_0:   read_mux = {1'b0, channelSelect, goFlag,
                                          converterOn};
            `OFS_CONTROL_1:   read_mux = {justifySelect, clockSelect, 2'b00,
                                          refSelect};
            `OFS_CONTROL_2:   read_mux = {triggerSelect, 4'h0};
            `OFS_RESULT_HIGH: read_mux = resultHigh;
            `OFS_RESULT_LOW:  read_mux = resultLow;
            `OFS_IRQ_STATUS:  read_mux = {7'h00, doneStatus};
            `OFS_IRQ_MASK:    read_mux = {7'h00, doneMask};
            default:          read_mux = 8'h00;
        endcase
    endfunction : read_mux

    function automatic logic trigger_hit(
        input logic [3:0]                sel,
        input logic [`TRIGGER_COUNT:1]   edges
    );
        if ((sel == 4'h0) || (sel > 4'hA))
            trigger_hit = 1'b0;
        else
            trigger_hit = edges[sel];
    endfunction : trigger_hit

    // Analog result and trigger inputs come from outside the clock domain
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            analogMeta <= 10'h000;
            analogSync <= 10'h000;
            trigMeta   <= '0;
            trigSync   <= '0;
            trigPrev   <= '0;
        end
        else
        begin
            analogMeta <= analogResult;
            analogSync <= analogMeta;
            trigMeta   <= triggerIn;
            trigSync   <= trigMeta;
            trigPrev   <= trigSync;
        end
    end

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready && !pslverr;
    assign wrEn       = accessDone && pwrite;
    assign rdEn       = accessDone && !pwrite;

    // Answer one cycle after setup; data and error are registered
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !addr_ok(paddr);
            if (setupPhase && !pwrite)
                prdata <= {24'h00_0000, read_mux(paddr)};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            converterOn   <= 1'b0;
            channelSelect <= 5'h00;
            justifySelect <= 1'b0;
            clockSelect   <= 3'h0;
            refSelect     <= 2'h0;
            triggerSelect <= 4'h0;
            doneMask      <= 1'b0;
        end
        else if (wrEn)
        begin
            unique case (paddr)
                `OFS_CONTROL_0:
                begin
                    converterOn   <= pwdata[`POS_CONVERTER_ON];
                    channelSelect <= pwdata[`POS_CHANNEL_HI:`POS_CHANNEL_LO];
                end
                `OFS_CONTROL_1:
                begin
                    justifySelect <= pwdata[`POS_JUSTIFY]; // RULE9
                    clockSelect   <= pwdata[`POS_CLKSEL_HI:`POS_CLKSEL_LO];
                    refSelect     <= pwdata[`POS_REFSEL_HI:`POS_REFSEL_LO];
                end
                `OFS_CONTROL_2:
                    triggerSelect <= pwdata[`POS_AUTO_TRIGGER_SELECT_HI:`POS_AUTO_TRIGGER_SELECT_LO];
                `OFS_IRQ_MASK:
                    doneMask      <= pwdata[`POS_DONE];
                default:
                begin
                end
            endcase
        end
    end

    assign trigHit  = trigger_hit(triggerSelect, trigSync & ~trigPrev);
    // Software or the selected trigger edge starts a conversion
    assign startReq = converterOn
                   && ((wrEn && (paddr == `OFS_CONTROL_0)
                        && pwdata[`POS_GO]) || trigHit);
    // Turning off the converter or writing go low aborts a conversion
    assign abortReq = !converterOn
                   || (wrEn && (paddr == `OFS_CONTROL_0)
                       && !pwdata[`POS_GO]);
    assign loadStrobe = (convState == CONVERT) && (convCount == 8'h00)
                     && !abortReq;

    // Conversion sequencer owns the go flag
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            convState <= IDLE;
            goFlag    <= 1'b0;
            convCount <= 8'h00;
        end
        else
        begin
            unique case (convState)
                IDLE:
                begin
                    if (startReq)
                    begin
                        convState <= CONVERT;
                        goFlag    <= 1'b1; // RULE7
                        convCount <= `CONV_CYCLES - 8'h01;
                    end
                end
                CONVERT:
                begin
                    if (abortReq)
                    begin
                        convState <= IDLE;
                        goFlag    <= 1'b0;
                    end
                    else if (loadStrobe)
                    begin
                        convState <= IDLE;
                        goFlag    <= 1'b0; // RULE7 RULE10
                    end
                    else
                        convCount <= convCount - 8'h01;
                end
                default:
                begin
                    convState <= IDLE;
                    goFlag    <= 1'b0;
                end
            endcase
        end
    end

    result_packer u_packer (
        .rightJustify     (justifySelect),
        .conversionResult (analogSync),
        .resultPair       (packedResult)
    );

    // Result bytes have no reset; a conversion load beats a software write
    always_ff @(posedge sys_clk)
    begin
        if (loadStrobe)
        begin
            resultHigh <= packedResult.high; // RULE10
            resultLow  <= packedResult.low;  // RULE10
        end
        else if (wrEn && (paddr == `OFS_RESULT_HIGH))
            resultHigh <= pwdata[7:0]; // RULE6
        else if (wrEn && (paddr == `OFS_RESULT_LOW))
            resultLow  <= pwdata[7:0]; // RULE6
    end

    // Sticky done flag; a read clears only what it returned, a set wins
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            doneStatus <= 1'b0;
        else if (loadStrobe)
            doneStatus <= 1'b1;
        else if (rdEn && (paddr == `OFS_IRQ_STATUS) && prdata[`POS_DONE])
            doneStatus <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= doneStatus && doneMask;
    end

    // Assertion helper: result bytes hold known data after the first conversion load
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            loadedOnce <= 1'b0;
        else if (loadStrobe)
            loadedOnce <= 1'b1;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    left_high_load_a: assert property ( // RULE1
        loadStrobe && !justifySelect
        |=> resultHigh == $past(analogSync[9:2]))
        else $error("Left justified high byte wrong");

    left_low_load_a: assert property ( // RULE2
        loadStrobe && !justifySelect
        |=> resultLow == {$past(analogSync[1:0]), 6'h00})
        else $error("Left justified low byte wrong");

    right_high_load_a: assert property ( // RULE3
        loadStrobe && justifySelect
        |=> resultHigh == {6'h00, $past(analogSync[9:8])})
        else $error("Right justified high byte wrong");

    right_low_load_a: assert property ( // RULE4
        loadStrobe && justifySelect
        |=> resultLow == $past(analogSync[7:0]))
        else $error("Right justified low byte wrong");

    result_hold_a: assert property ( // RULE6
        loadedOnce && !loadStrobe && !(wrEn && paddr == `OFS_RESULT_HIGH)
        |=> $stable(resultHigh))
        else $error("High result byte changed without cause");

    go_clear_done_a: assert property ( // RULE7
        loadStrobe |=> !goFlag && doneStatus ##1 !goFlag)
        else $error("Go flag not cleared on completion");

    conv_length_a: assert property ( // RULE7
        loadStrobe |-> $past(goFlag, ConvDepth - 1) && goFlag
                       && !$past(goFlag, ConvDepth))
        else $error("Conversion length wrong");

    unused_zero_a: assert property ( // RULE8
        loadStrobe |=> ($past(justifySelect) ? resultHigh[7:2]
                                             : resultLow[5:0]) == 6'h00)
        else $error("Unused result bits not zero");

    justify_read_a: assert property ( // RULE9
        setupPhase && !pwrite && paddr == `OFS_CONTROL_1
        |=> prdata[`POS_JUSTIFY] == $past(justifySelect))
        else $error("Justify select bit misplaced");

    load_with_go_a: assert property ( // RULE10
        $fell(goFlag) && $past(convCount) == 8'h00 && $past(converterOn)
        && !$past(abortReq)
        |-> resultHigh == $past(packedResult.high)
            && resultLow == $past(packedResult.low))
        else $error("Result not loaded when go cleared");

    irq_level_a: assert property (
        doneStatus && doneMask |=> irq)
        else $error("Interrupt not raised");

    left_conv_c: cover property (loadStrobe && !justifySelect);
    right_conv_c: cover property (loadStrobe && justifySelect);
    trig_start_c: cover property (trigHit && convState == IDLE);
    abort_c: cover property (convState == CONVERT && abortReq);

endmodule : adc_result_formatting

/* File: testbench/adc_result_formatting_tb_top.sv */
// Self-checking bench for the converter result formatting block
`timescale 1ns/1ps
`include "adc_result_params.svh"

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
        end \
    end

module adc_result_formatting_tb_top;
    import adc_result_pkg::*;

    logic                     sys_clk;
    logic                     arst_n;
    logic [7:0]               paddr;
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [31:0]              pwdata;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
    logic [9:0]               analogResult;
    logic [`TRIGGER_COUNT:1]  triggerIn;
    logic                     irq;
    logic                     converterOn;
    logic [4:0]               channelSelect;
    int                       failures;
    int                       num_checks;
    int                       cycles;
    logic [31:0]              rd;
    logic                     err;
    logic [15:0]              expPair;
    logic [4:0]               ch;
    logic                     rj;
    int                       sel;

    adc_result_formatting dut (
        .sys_clk       (sys_clk),
        .arst_n        (arst_n),
        .paddr         (paddr),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .analogResult  (analogResult),
        .triggerIn     (triggerIn),
        .irq           (irq),
        .converterOn   (converterOn),
        .channelSelect (channelSelect)
    );

    always #50 sys_clk = ~sys_clk;

    // Expected high and low bytes for a justification choice
    function automatic logic [15:0] pack(input logic rjust,
                                         input logic [9:0] r);
        pack = rjust ? {6'h00, r[9:8], r[7:0]} : {r[9:2], r[1:0], 6'h00};
    endfunction : pack

    task automatic end_of_test;
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // One APB transfer; pready and read data are taken at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Poll the go flag until hardware clears it
    task automatic wait_done;
        int n;
        n = 0;
        apb(1'b0, `OFS_CONTROL_0, 32'h0000_0000);
        while (rd[`POS_GO] !== 1'b0 && n < 30)
        begin
            n++;
            apb(1'b0, `OFS_CONTROL_0, 32'h0000_0000);
        end
        `CHK(rd[`POS_GO], 1'b0)
    endtask : wait_done

    task automatic check_result(input logic [15:0] e);
        apb(1'b0, `OFS_RESULT_HIGH, 32'h0000_0000);
        `CHK(rd[7:0], e[15:8])
        apb(1'b0, `OFS_RESULT_LOW, 32'h0000_0000);
        `CHK(rd[7:0], e[7:0])
    endtask : check_result

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    initial
    begin
        sys_clk = 0;
        arst_n = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        analogResult = 10'h000;
        triggerIn = '0;
        failures = 0;
        num_checks = 0;
        cycles = 0;
        void'($urandom(41));
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(1'b0, `OFS_CONTROL_0, 32'h0000_0000);
        `CHK(rd[7:0], `CONTROL_RESET)
        `CHK(converterOn, 1'b0)
        // Result bytes read/write and kept across reset
        apb(1'b1, `OFS_RESULT_HIGH, 32'h0000_00A5);
        apb(1'b1, `OFS_RESULT_LOW, 32'h0000_003C);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        check_result(16'hA53C);
        // Unmapped and unaligned addresses
        apb(1'b0, 8'h1C, 32'h0000_0000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, 8'h02, 32'h0000_00FF);
        `CHK(err, 1'b1)
        // Software conversions, both justifications, corners then random
        for (int i = 0; i < 10; i++)
        begin
            rj = i[0];
            ch = 5'($urandom_range(31));
            analogResult <= (i < 2) ? 10'h3FF : (i < 4) ? 10'h000
                                              : 10'($urandom);
            apb(1'b1, `OFS_IRQ_MASK, {31'h0, i[1]});
            apb(1'b1, `OFS_CONTROL_1, {24'h0, rj, 7'h00});
            apb(1'b0, `OFS_CONTROL_1, 32'h0000_0000);
            `CHK(rd[`POS_JUSTIFY], rj)
            expPair = pack(rj, analogResult);
            apb(1'b1, `OFS_CONTROL_0, {24'h0, 1'b0, ch, 2'b01});
            repeat (`ACQ_CYCLES) @(posedge sys_clk);
            `CHK(channelSelect, ch)
            `CHK(converterOn, 1'b1)
            apb(1'b1, `OFS_CONTROL_0, {24'h0, 1'b0, ch, 2'b11});
            apb(1'b0, `OFS_CONTROL_0, 32'h0000_0000);
            `CHK(rd[`POS_GO], 1'b1)
            wait_done();
            @(negedge sys_clk);
            `CHK(irq, i[1])
            check_result(expPair);
            apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
            `CHK(rd[`POS_DONE], 1'b1)
            repeat (2) @(negedge sys_clk);
            `CHK(irq, 1'b0)
        end
        // Trigger-started conversion
        sel = $urandom_range(10, 1);
        analogResult <= 10'($urandom);
        apb(1'b1, `OFS_CONTROL_0, 32'h0000_0001);
        apb(1'b1, `OFS_CONTROL_2, 32'(sel << 4));
        expPair = pack(rj, analogResult);
        repeat (`ACQ_CYCLES) @(posedge sys_clk);
        triggerIn[sel] <= 1'b1;
        repeat (20) @(posedge sys_clk);
        triggerIn[sel] <= 1'b0;
        check_result(expPair);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK(rd[`POS_DONE], 1'b1)
        // Aborted conversion: no load and no done status
        analogResult <= ~analogResult;
        apb(1'b1, `OFS_CONTROL_0, 32'h0000_0003);
        apb(1'b1, `OFS_CONTROL_0, 32'h0000_0001);
        repeat (20) @(posedge sys_clk);
        apb(1'b0, `OFS_CONTROL_0, 32'h0000_0000);
        `CHK(rd[`POS_GO], 1'b0)
        check_result(expPair);
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
        `CHK(rd[`POS_DONE], 1'b0)
        end_of_test();
    end
endmodule : adc_result_formatting_tb_top
